// *** dabc_defs.vh ***
// Purpose: shared constants for the align/bit-reverse/branch/compare datapath
// Assumes: 32-bit general registers, single core clock
// Notes:   register offsets are byte addresses on the AXI4-Lite slave
`ifndef DABC_DEFS_VH
`define DABC_DEFS_VH

`define DABC_OP_W          4
`define DABC_OP_NONE       4'h0
`define DABC_OP_ALIGN      4'h1
`define DABC_OP_HALFWORD_BIT_REVERSE     4'h2
`define DABC_OP_BR_DELAY   4'h3
`define DABC_OP_BR_COMPACT 4'h4
`define DABC_OP_CMP_PH     4'h5
`define DABC_OP_CMP_BOTH   4'h6
`define DABC_OP_CMP_REG    4'h7

`define DABC_COND_EQ       2'h0
`define DABC_COND_LT       2'h1
`define DABC_COND_LE       2'h2

`define DABC_POS_LIMIT     6'h20
`define DABC_CC_LO         24
`define DABC_CC_HI         27

`define DABC_ADDR_CTRL     4'h0
`define DABC_ADDR_STATUS   4'h4
`define DABC_ADDR_MASK     4'h8
`define DABC_ADDR_FLAGS    4'hc

`define DABC_CTRL_RST      2'h3
`define DABC_EV_W          4
`define DABC_EV_BRANCH     0
`define DABC_EV_RESV       1
`define DABC_EV_DISABLED   2
`define DABC_EV_CMP        3

`define DABC_RESP_OKAY     2'h0
`define DABC_RESP_SLVERR   2'h2

`endif

// *** dabc_lane_cmp.v ***
// Purpose: one lane of the shared compare array
// Assumes: cond is eq, lt or le
// Notes:   signedness chosen per instance
`timescale 1ns/10ps
`default_nettype none
`include "dabc_defs.vh"
module dabc_lane_cmp #(
  parameter W      = 8,
  parameter SIGNED = 0
) (
  input  wire [W-1:0] i_a,
  input  wire [W-1:0] i_b,
  input  wire [1:0]   i_cond,
  output reg          o_res
);
  wire [W:0] a_x = {(SIGNED != 0) & i_a[W-1], i_a};
  wire [W:0] b_x = {(SIGNED != 0) & i_b[W-1], i_b};
  wire       eq  = (i_a == i_b);
  wire       lt  = ($signed(a_x) < $signed(b_x));
  always @* begin
    case (i_cond)
      `DABC_COND_EQ: o_res = eq;
      `DABC_COND_LT: o_res = lt;
      `DABC_COND_LE: o_res = lt | eq;
      default:       o_res = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// *** dabc_axil_slave.v ***
// Purpose: AXI4-Lite register slave for the datapath
// Assumes: one write and one read outstanding at most
// Notes:   status is write-one-to-clear, set wins over clear
`timescale 1ns/10ps
`default_nettype none
`include "dabc_defs.vh"
module dabc_axil_slave (
  input  wire        i_clk,
  input  wire        i_nrst,
  input  wire [3:0]  i_awaddr,
  input  wire        i_awvalid,
  output wire        o_awready,
  input  wire [31:0] i_wdata,
  input  wire [3:0]  i_wstrb,
  input  wire        i_wvalid,
  output wire        o_wready,
  output reg  [1:0]  o_bresp,
  output reg         o_bvalid,
  input  wire        i_bready,
  input  wire [3:0]  i_araddr,
  input  wire        i_arvalid,
  output wire        o_arready,
  output reg  [31:0] o_rdata,
  output reg  [1:0]  o_rresp,
  output reg         o_rvalid,
  input  wire        i_rready,
  input  wire [3:0]  i_events,
  input  wire [31:0] i_flags,
  output reg  [1:0]  o_ctrl,
  output wire        o_irq
);
  reg  [3:0]  aw_r;
  reg         aw_have_r;
  reg  [31:0] wd_r;
  reg  [3:0]  ws_r;
  reg         w_have_r;
  reg  [3:0]  status_r;
  reg  [3:0]  mask_r;
  wire        do_wr = aw_have_r & w_have_r & ~o_bvalid;
  wire        clr   = do_wr & (aw_r == `DABC_ADDR_STATUS) & ws_r[0];
  assign o_awready = ~aw_have_r & ~o_bvalid;
  assign o_wready  = ~w_have_r & ~o_bvalid;
  assign o_arready = ~o_rvalid;
  assign o_irq     = |(status_r & mask_r);
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      aw_r      <= 4'h0;
      aw_have_r <= 1'b0;
      wd_r      <= 32'h0;
      ws_r      <= 4'h0;
      w_have_r  <= 1'b0;
      o_bvalid  <= 1'b0;
      o_bresp   <= `DABC_RESP_OKAY;
      o_rvalid  <= 1'b0;
      o_rresp   <= `DABC_RESP_OKAY;
      o_rdata   <= 32'h0;
      status_r  <= 4'h0;
      mask_r    <= 4'h0;
      o_ctrl    <= `DABC_CTRL_RST;
    end else begin
      if (i_awvalid & o_awready) begin
        aw_r      <= i_awaddr;
        aw_have_r <= 1'b1;
      end
      if (i_wvalid & o_wready) begin
        wd_r     <= i_wdata;
        ws_r     <= i_wstrb;
        w_have_r <= 1'b1;
      end
      status_r <= (status_r & ~(clr ? wd_r[3:0] : 4'h0)) | i_events;
      if (do_wr) begin
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
        o_bvalid  <= 1'b1;
        o_bresp   <= `DABC_RESP_OKAY;
        case (aw_r)
          `DABC_ADDR_CTRL:   if (ws_r[0]) o_ctrl <= wd_r[1:0];
          `DABC_ADDR_STATUS: ;
          `DABC_ADDR_MASK:   if (ws_r[0]) mask_r <= wd_r[3:0];
          `DABC_ADDR_FLAGS:  ;
          default:           o_bresp <= `DABC_RESP_SLVERR;
        endcase
      end else if (o_bvalid & i_bready) begin
        o_bvalid <= 1'b0;
      end
      if (i_arvalid & o_arready) begin
        o_rvalid <= 1'b1;
        o_rresp  <= `DABC_RESP_OKAY;
        case (i_araddr)
          `DABC_ADDR_CTRL:   o_rdata <= {30'h0, o_ctrl};
          `DABC_ADDR_STATUS: o_rdata <= {28'h0, status_r};
          `DABC_ADDR_MASK:   o_rdata <= {28'h0, mask_r};
          `DABC_ADDR_FLAGS:  o_rdata <= i_flags;
          default: begin
            o_rdata <= 32'h0;
            o_rresp <= `DABC_RESP_SLVERR;
          end
        endcase
      end else if (o_rvalid & i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// *** dabc_datapath.v ***
// Purpose: execute stage for byte align, bit reverse, position branches, compares
// Assumes: pipeline presents one decoded op per cycle with operands and pc
// Notes:   results registered one cycle after i_valid; flags held locally
`timescale 1ns/10ps
`default_nettype none
`include "dabc_defs.vh"
// How it works
// (RULE1) align: amount 1 or 3 gives target<<8n OR source>>8(4-n); 0/2 undefined
// (RULE2) bit reverse puts low source halfword reversed into low result halfword
// (RULE3) bit reverse zeroes every result bit above bit 15
// (RULE4) branch target is next pc plus sign-extended offset shifted left two
// (RULE5) delayed branch taken if position >= 32, redirect after delay slot
// (RULE6) compact branch taken if position >= 32, no delay slot
// (RULE7) control-transfer op in delayed branch slot raises reserved exception; code raises it only while ctrl bit 1 (newest) is set
// (RULE8) control-transfer op right after compact branch raises reserved exception
// (RULE9) both branches may raise reserved or extension-disabled exception instead
// (RULE10) halfword compare is signed, eq/lt/le per element
// (RULE11) halfword compare: upper result to flag 25, lower to flag 24
// (RULE12) both-target byte compare: unsigned results to flags 27..24, top byte at 27
// (RULE13) both-target byte compare also writes results to dest bits 3..0, rest zero
// (RULE14) register-only byte compare writes results to dest low four bits, rest zero
// (RULE15) condition decoded from encoding; one comparator array serves all compares
module dabc_datapath #(
  parameter XLEN = 32
) (
  input  wire            i_clk,
  input  wire            i_nrst,
  input  wire            i_valid,
  input  wire [3:0]      i_op,
  input  wire [1:0]      i_cond,
  input  wire [1:0]      i_byte_shift_amount,
  input  wire [15:0]     i_offset,
  input  wire [31:0]     i_source_a_reg,
  input  wire [31:0]     i_source_b_reg,
  input  wire [31:0]     i_pc,
  input  wire [5:0]      i_pos,
  input  wire            i_op_is_cti,
  input  wire            i_op_reserved,
  output reg  [31:0]     o_result,
  output reg             o_result_we,
  output reg  [3:0]      o_cc_flags,
  output reg             o_cc_we,
  output reg  [31:0]     o_target,
  output reg             o_redirect,
  output reg             o_resv_exc,
  output reg             o_dsp_dis_exc,
  input  wire [3:0]      i_awaddr,
  input  wire            i_awvalid,
  output wire            o_awready,
  input  wire [31:0]     i_wdata,
  input  wire [3:0]      i_wstrb,
  input  wire            i_wvalid,
  output wire            o_wready,
  output wire [1:0]      o_bresp,
  output wire            o_bvalid,
  input  wire            i_bready,
  input  wire [3:0]      i_araddr,
  input  wire            i_arvalid,
  output wire            o_arready,
  output wire [31:0]     o_rdata,
  output wire [1:0]      o_rresp,
  output wire            o_rvalid,
  input  wire            i_rready,
  output wire            o_irq
);
  localparam ST_IDLE  = 3'b001;
  localparam ST_DSLOT = 3'b010;
  localparam ST_FSLOT = 3'b100;

  reg  [2:0]  state_r;
  reg  [2:0]  state_nxt;
  reg  [31:0] pend_target_r;
  reg         pend_taken_r;
  reg  [3:0]  cc_r;
  wire [1:0]  ctrl;
  wire        ext_en   = ctrl[0];
  wire        newest   = ctrl[1];
  wire [3:0]  byte_res;
  wire [1:0]  half_res;
  wire [3:0]  events;

  // four byte lanes (unsigned) and two halfword lanes (signed) share one cond
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_byte
      dabc_lane_cmp #(.W(8), .SIGNED(0)) u_lane (
        .i_a    (i_source_a_reg[8*g+7:8*g]),
        .i_b    (i_source_b_reg[8*g+7:8*g]),
        .i_cond (i_cond),  // see (RULE15)
        .o_res  (byte_res[g])
      );
    end
    for (g = 0; g < 2; g = g + 1) begin : g_half
      dabc_lane_cmp #(.W(16), .SIGNED(1)) u_lane (
        .i_a    (i_source_a_reg[16*g+15:16*g]),
        .i_b    (i_source_b_reg[16*g+15:16*g]),
        .i_cond (i_cond),  // see (RULE10)
        .o_res  (half_res[g])
      );
    end
  endgenerate

  wire [31:0] next_pc  = i_pc + 32'h4;
  wire [31:0] se_off   = {{14{i_offset[15]}}, i_offset, 2'h0};  // see (RULE4)
  wire [31:0] br_tgt   = next_pc + se_off;                     // see (RULE4)
  wire        pos_ge   = (i_pos >= `DABC_POS_LIMIT);            // see (RULE5) (RULE6)
  wire        is_br    = (i_op == `DABC_OP_BR_DELAY) | (i_op == `DABC_OP_BR_COMPACT);
  wire        br_resv  = i_valid & is_br & i_op_reserved;       // see (RULE9)
  wire        br_dis   = i_valid & is_br & ~ext_en & ~i_op_reserved;  // see (RULE9)
  wire        br_ok    = i_valid & is_br & ~i_op_reserved & ext_en;
  wire        dslot_cti = i_valid & (state_r == ST_DSLOT) & i_op_is_cti & newest;  // see (RULE7)
  wire        fslot_cti = i_valid & (state_r == ST_FSLOT) & i_op_is_cti;           // see (RULE8)

  reg  [31:0] align_v;
  always @* begin
    case (i_byte_shift_amount)
      2'h1:    align_v = (i_source_b_reg << 8) | (i_source_a_reg >> 24);  // see (RULE1)
      2'h3:    align_v = (i_source_b_reg << 24) | (i_source_a_reg >> 8);  // see (RULE1)
      default: align_v = i_source_b_reg;
    endcase
  end

  reg [15:0] rev_v;
  integer k;
  always @* begin
    rev_v = 16'h0;
    for (k = 0; k < 16; k = k + 1) begin
      rev_v[15-k] = i_source_b_reg[k];  // see (RULE2)
    end
  end

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:  state_nxt = ST_IDLE;
      ST_DSLOT: if (i_valid) state_nxt = ST_IDLE;
      ST_FSLOT: if (i_valid) state_nxt = ST_IDLE;
      default:  state_nxt = ST_IDLE;
    endcase
    // an executed branch opens its own slot, even when it issues inside one
    if (br_ok && !dslot_cti && !fslot_cti) begin
      state_nxt = (i_op == `DABC_OP_BR_DELAY) ? ST_DSLOT : ST_FSLOT;  // see (RULE7) (RULE8)
    end
  end

  assign events = {i_valid & (i_op >= `DABC_OP_CMP_PH) & (i_op <= `DABC_OP_CMP_BOTH),
                   br_dis,
                   br_resv | dslot_cti | fslot_cti,
                   br_ok & pos_ge};

  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_r       <= ST_IDLE;
      pend_target_r <= 32'h0;
      pend_taken_r  <= 1'b0;
      cc_r          <= 4'h0;
      o_result      <= 32'h0;
      o_result_we   <= 1'b0;
      o_cc_flags    <= 4'h0;
      o_cc_we       <= 1'b0;
      o_target      <= 32'h0;
      o_redirect    <= 1'b0;
      o_resv_exc    <= 1'b0;
      o_dsp_dis_exc <= 1'b0;
    end else begin
      state_r       <= state_nxt;
      o_result_we   <= 1'b0;
      o_cc_we       <= 1'b0;
      o_redirect    <= 1'b0;
      o_resv_exc    <= br_resv | dslot_cti | fslot_cti;  // see (RULE7) (RULE8) (RULE9)
      o_dsp_dis_exc <= br_dis;                           // see (RULE9)
      if (state_r == ST_DSLOT && i_valid) begin
        // delay-slot op has issued: now redirect
        o_redirect   <= pend_taken_r & ~dslot_cti;  // see (RULE5)
        o_target     <= pend_target_r;
        pend_taken_r <= 1'b0;
      end
      if (i_valid && !dslot_cti && !fslot_cti) begin
        case (i_op)
          `DABC_OP_ALIGN: begin
            o_result    <= align_v;
            o_result_we <= 1'b1;
          end
          `DABC_OP_HALFWORD_BIT_REVERSE: begin
            o_result    <= {16'h0, rev_v};  // see (RULE3)
            o_result_we <= 1'b1;
          end
          `DABC_OP_BR_DELAY: if (br_ok) begin
            pend_taken_r  <= pos_ge;  // see (RULE5)
            pend_target_r <= br_tgt;
          end
          `DABC_OP_BR_COMPACT: if (br_ok) begin
            o_redirect <= pos_ge;  // see (RULE6)
            o_target   <= br_tgt;
          end
          `DABC_OP_CMP_PH: begin
            cc_r[1:0]  <= half_res;  // see (RULE11)
            o_cc_flags <= {cc_r[3:2], half_res};
            o_cc_we    <= 1'b1;
          end
          `DABC_OP_CMP_BOTH: begin
            cc_r        <= byte_res;  // see (RULE12)
            o_cc_flags  <= byte_res;
            o_cc_we     <= 1'b1;
            o_result    <= {28'h0, byte_res};  // see (RULE13)
            o_result_we <= 1'b1;
          end
          `DABC_OP_CMP_REG: begin
            o_result    <= {28'h0, byte_res};  // see (RULE14)
            o_result_we <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  dabc_axil_slave u_regs (
    .i_clk     (i_clk),
    .i_nrst    (i_nrst),
    .i_awaddr  (i_awaddr),
    .i_awvalid (i_awvalid),
    .o_awready (o_awready),
    .i_wdata   (i_wdata),
    .i_wstrb   (i_wstrb),
    .i_wvalid  (i_wvalid),
    .o_wready  (o_wready),
    .o_bresp   (o_bresp),
    .o_bvalid  (o_bvalid),
    .i_bready  (i_bready),
    .i_araddr  (i_araddr),
    .i_arvalid (i_arvalid),
    .o_arready (o_arready),
    .o_rdata   (o_rdata),
    .o_rresp   (o_rresp),
    .o_rvalid  (o_rvalid),
    .i_rready  (i_rready),
    .i_events  (events),
    .i_flags   ({4'h0, cc_r, 18'h0, i_pos}),
    .o_ctrl    (ctrl),
    .o_irq     (o_irq)
  );
endmodule
`default_nettype wire

// *** dabc_dp_monitor.sv ***
// Purpose: port checks on the align/bit-reverse/branch/compare datapath
// Assumes: the extension stays enabled unless a disabled exception shows
// Notes:   expected values are staged one cycle in helper registers, the delayed target (tgt2_r) two
`timescale 1ns/10ps
`default_nettype none
`include "dabc_defs.vh"
module dabc_dp_monitor (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_valid,
  input  wire logic [3:0]  i_op,
  input  wire logic [1:0]  i_cond,
  input  wire logic [1:0]  i_byte_shift_amount,
  input  wire logic [15:0] i_offset,
  input  wire logic [31:0] i_source_a_reg,
  input  wire logic [31:0] i_source_b_reg,
  input  wire logic [31:0] i_pc,
  input  wire logic [5:0]  i_pos,
  input  wire logic        i_op_is_cti,
  input  wire logic        i_op_reserved,
  input  wire logic [31:0] o_result,
  input  wire logic        o_result_we,
  input  wire logic [3:0]  o_cc_flags,
  input  wire logic        o_cc_we,
  input  wire logic [31:0] o_target,
  input  wire logic        o_redirect,
  input  wire logic        o_resv_exc,
  input  wire logic        o_dsp_dis_exc
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  wire logic [31:0] sa = i_source_a_reg;
  wire logic [31:0] sb = i_source_b_reg;
  logic      [1:0]  hexp_r;
  logic      [3:0]  bexp_r;
  logic      [31:0] aln_r;
  logic      [15:0] rev_r;
  logic      [31:0] tgt_r;
  logic      [31:0] tgt2_r;
  // one compare for every lane width: operands arrive already extended
  function automatic logic cmpf(input logic [16:0] a, input logic [16:0] b, input logic [1:0] c);
    cmpf = (c == `DABC_COND_EQ) ? (a == b) : (c == `DABC_COND_LT) ? ($signed(a) < $signed(b)) :
           (c == `DABC_COND_LE) ? ($signed(a) <= $signed(b)) : 1'b0;
  endfunction
  always @(posedge i_clk) begin
    hexp_r[1] <= cmpf({sa[31], sa[31:16]}, {sb[31], sb[31:16]}, i_cond);
    hexp_r[0] <= cmpf({sa[15], sa[15:0]}, {sb[15], sb[15:0]}, i_cond);
    for (int i = 0; i < 4; i++) bexp_r[i] <= cmpf({9'h0, sa[8*i+:8]}, {9'h0, sb[8*i+:8]}, i_cond);
    aln_r  <= (sb << (8 * i_byte_shift_amount)) | (sa >> (8 * (4 - i_byte_shift_amount)));
    rev_r  <= {<<{sb[15:0]}};
    tgt_r  <= i_pc + 32'h4 + {{14{i_offset[15]}}, i_offset, 2'b00};
    tgt2_r <= tgt_r;
  end
  a_align_combine: assert property (
    i_valid && i_op == `DABC_OP_ALIGN && i_byte_shift_amount[0] |=> o_result_we && o_result == aln_r)
    else $error("align result wrong");
  a_halfword_bit_reverse_fill: assert property (
    i_valid && i_op == `DABC_OP_HALFWORD_BIT_REVERSE |=> o_result_we && o_result == {16'h0, rev_r})
    else $error("bit reverse result wrong");
  a_compact_target: assert property (
    i_valid && i_op == `DABC_OP_BR_COMPACT && i_pos >= `DABC_POS_LIMIT && !i_op_reserved
    && !i_op_is_cti |=> o_dsp_dis_exc || (o_redirect && o_target == tgt_r))
    else $error("compact branch target wrong");
  a_delay_slot: assert property (
    i_valid && i_op == `DABC_OP_BR_DELAY && i_pos >= `DABC_POS_LIMIT && !i_op_reserved
    && !i_op_is_cti ##1 i_valid && !i_op_is_cti
    |-> o_dsp_dis_exc or (!o_redirect ##1 (o_redirect && o_target == tgt2_r)))
    else $error("delayed branch redirect wrong");
  a_half_cmp: assert property (
    i_valid && i_op == `DABC_OP_CMP_PH |=> o_cc_we && o_cc_flags[1:0] == hexp_r)
    else $error("halfword compare flags wrong");
  a_byte_both: assert property (
    i_valid && i_op == `DABC_OP_CMP_BOTH
    |=> o_cc_we && o_result_we && o_cc_flags == bexp_r && o_result == {28'h0, bexp_r})
    else $error("both-target byte compare wrong");
  a_byte_reg: assert property (
    i_valid && i_op == `DABC_OP_CMP_REG |=> o_result_we && o_result == {28'h0, bexp_r})
    else $error("register byte compare wrong");
  a_compact_cti: assert property (
    i_valid && i_op == `DABC_OP_BR_COMPACT && !i_op_reserved
    ##1 i_valid && i_op_is_cti && !o_dsp_dis_exc && !o_resv_exc
    |=> o_resv_exc && !o_redirect)
    else $error("transfer after compact branch not refused");
  a_branch_resv: assert property (
    i_valid && (i_op == `DABC_OP_BR_DELAY || i_op == `DABC_OP_BR_COMPACT) && i_op_reserved
    && !i_op_is_cti |=> o_resv_exc && !o_redirect)
    else $error("reserved branch executed");
endmodule
`default_nettype wire

// *** dabc_pipe_model.sv ***
// Purpose: pipeline side of the datapath: write-back and fetch redirect
// Assumes: results and redirects are one-cycle pulses
// Notes:   fetch pc only moves on a redirect
`timescale 1ns/10ps
`default_nettype none
module dabc_pipe_model (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic [31:0] i_result,
  input  wire logic        i_result_we,
  input  wire logic [31:0] i_target,
  input  wire logic        i_redirect,
  output var  logic [31:0] o_wb,
  output var  logic [31:0] o_fetch_pc
);
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_wb       <= 32'h0;
      o_fetch_pc <= 32'h0;
    end else begin
      if (i_result_we) o_wb <= i_result;
      if (i_redirect) o_fetch_pc <= i_target;
    end
  end
endmodule
`default_nettype wire

// *** dabc_tb_top.sv ***
// Purpose: directed tests of the datapath and its register slave
// Assumes: ops issued one per cycle, checked one cycle after they are taken
// Notes:   op and idle return 1 ns after an edge, where outputs are settled; axr and axw return on the edge
`timescale 1ns/10ps
`default_nettype none
`include "dabc_defs.vh"
module tb_top;
  logic        i_clk, i_nrst, i_valid, i_op_is_cti, i_op_reserved;
  logic [3:0]  i_op, i_awaddr, i_wstrb, i_araddr;
  logic [1:0]  i_cond, i_byte_shift_amount, o_bresp, o_rresp, rsp, brsp;
  logic [15:0] i_offset;
  logic [5:0]  i_pos;
  logic [31:0] i_source_a_reg, i_source_b_reg, i_pc, i_wdata, o_rdata, o_result, o_target, rd;
  logic [31:0] wb, fpc;
  logic        i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, o_awready, o_wready;
  logic        o_bvalid, o_arready, o_rvalid, o_irq, o_result_we, o_cc_we, o_redirect;
  logic        o_resv_exc, o_dsp_dis_exc;
  logic [3:0]  o_cc_flags;
  logic [1:0]  hx [3] = '{2'h1, 2'h2, 2'h3};
  logic [3:0]  bx [3] = '{4'h4, 4'h9, 4'hd};
  int          bad_count, checks_done;
  dabc_datapath uut (.*);
  dabc_pipe_model u_pipe (.i_clk(i_clk), .i_nrst(i_nrst), .i_result(o_result),
    .i_result_we(o_result_we), .i_target(o_target), .i_redirect(o_redirect), .o_wb(wb),
    .o_fetch_pc(fpc));
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic op(input logic [3:0] o, input logic [1:0] c, input logic [5:0] p,
                    input logic [31:0] a, input logic [31:0] b, input logic t, input logic r);
    @(posedge i_clk);
    i_valid <= (o != `DABC_OP_NONE);
    {i_op, i_cond, i_byte_shift_amount, i_pos} <= {o, c, c, p};
    {i_source_a_reg, i_pc, i_source_b_reg, i_offset} <= {a, a, b, b[15:0]};
    {i_op_is_cti, i_op_reserved} <= {t, r};
    #1;
  endtask
  task automatic idle;
    op(`DABC_OP_NONE, 2'h0, 6'h0, 32'h0, 32'h0, 1'b0, 1'b0);
  endtask
  task automatic axw(input logic [3:0] ad, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    {i_awaddr, i_wdata, i_awvalid, i_wvalid, i_bready} <= {ad, d, 3'b111};
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
    end while (!o_bvalid && n < 50);
    if (!o_bvalid) bad_count++;
    brsp = o_bresp;
    i_bready <= 1'b0;
  endtask
  task automatic axr(input logic [3:0] ad);
    int n;
    @(posedge i_clk);
    {i_araddr, i_arvalid, i_rready} <= {ad, 2'b11};
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
      if (o_arready) i_arvalid <= 1'b0;
      {rd, rsp} = {o_rdata, o_rresp};
    end while (!o_rvalid && n < 50);
    if (!o_rvalid) bad_count++;
    i_rready <= 1'b0;
  endtask
  task automatic close_out;
    if (bad_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    close_out;
  end
  initial begin
    {i_nrst, i_valid, i_op, i_cond, i_byte_shift_amount, i_pos, i_op_is_cti} = '0;
    {i_source_a_reg, i_source_b_reg, i_pc, i_offset, i_op_reserved} = '0;
    {i_awaddr, i_wdata, i_awvalid, i_wvalid, i_bready, i_araddr, i_arvalid, i_rready} = '0;
    i_wstrb = 4'hf;
    repeat (6) @(posedge i_clk);
    i_nrst <= 1'b1;
    axr(`DABC_ADDR_CTRL);
    chk("ctrl", rd, 32'h3);
    axr(`DABC_ADDR_MASK);
    chk("mask", rd, 32'h0);
    axr(4'h6);
    chk("unmapped resp", {30'h0, rsp}, {30'h0, `DABC_RESP_SLVERR});
    axw(4'h6, 32'h0);
    chk("unmapped wr resp", {30'h0, brsp}, {30'h0, `DABC_RESP_SLVERR});
    op(`DABC_OP_ALIGN, 2'h1, 6'h0, 32'haabbccdd, 32'h11223344, 1'b0, 1'b0);
    op(`DABC_OP_ALIGN, 2'h3, 6'h0, 32'haabbccdd, 32'h11223344, 1'b0, 1'b0);
    chk("align one", o_result, 32'h223344aa);
    op(`DABC_OP_BR_DELAY, 2'h0, 6'h3f, 32'h2000, 32'h10, 1'b0, 1'b0);
    chk("align three", o_result, 32'h44aabbcc);
    op(`DABC_OP_HALFWORD_BIT_REVERSE, 2'h0, 6'h0, 32'h0, 32'hffff8003, 1'b0, 1'b0);
    chk("early redirect", o_redirect, 32'h0);
    idle;
    chk("slot result", o_result, 32'h0000c001);
    chk("delayed target", {o_target[31:1], o_redirect}, 32'h2045);
    idle;
    chk("fetch pc", fpc, 32'h2044);
    op(`DABC_OP_BR_COMPACT, 2'h0, 6'h20, 32'h1000, 32'hfffe, 1'b0, 1'b0);
    op(`DABC_OP_BR_COMPACT, 2'h0, 6'h1f, 32'h1000, 32'hfffe, 1'b0, 1'b0);
    chk("compact target", {o_target[31:1], o_redirect}, 32'h0ffd);
    op(`DABC_OP_BR_DELAY, 2'h0, 6'h3f, 32'h2000, 32'h10, 1'b0, 1'b0);
    chk("untaken", o_redirect, 32'h0);
    op(`DABC_OP_BR_COMPACT, 2'h0, 6'h0, 32'h0, 32'h0, 1'b1, 1'b0);
    op(`DABC_OP_BR_COMPACT, 2'h0, 6'h0, 32'h0, 32'h0, 1'b0, 1'b0);
    chk("delay slot refused", o_resv_exc, 32'h1);
    op(`DABC_OP_BR_COMPACT, 2'h0, 6'h20, 32'h0, 32'h0, 1'b1, 1'b0);
    op(`DABC_OP_BR_COMPACT, 2'h0, 6'h20, 32'h0, 32'h0, 1'b0, 1'b1);
    chk("forbidden slot", {o_resv_exc, o_redirect}, 32'h2);
    idle;
    chk("reserved branch", {o_resv_exc, o_redirect}, 32'h2);
    axw(`DABC_ADDR_CTRL, 32'h1);
    chk("ctrl wr resp", {30'h0, brsp}, 32'h0);
    op(`DABC_OP_BR_DELAY, 2'h0, 6'h3f, 32'h2000, 32'h10, 1'b0, 1'b0);
    op(`DABC_OP_HALFWORD_BIT_REVERSE, 2'h0, 6'h0, 32'h0, 32'hffff8003, 1'b1, 1'b0);
    idle;
    chk("older release slot", {o_resv_exc, o_redirect}, 32'h1);
    axw(`DABC_ADDR_CTRL, 32'h2);
    op(`DABC_OP_BR_COMPACT, 2'h0, 6'h20, 32'h0, 32'h0, 1'b0, 1'b0);
    idle;
    chk("disabled branch", {o_dsp_dis_exc, o_redirect}, 32'h2);
    axw(`DABC_ADDR_CTRL, 32'h3);
    for (int k = 0; k < 3; k++) begin
      op(`DABC_OP_CMP_PH, k[1:0], 6'h0, 32'h80000005, 32'h00010005, 1'b0, 1'b0);
      op(`DABC_OP_CMP_BOTH, k[1:0], 6'h0, 32'h0180ff10, 32'h02800120, 1'b0, 1'b0);
      chk("half cmp", {o_cc_we, o_cc_flags[1:0]}, {29'h1, hx[k]});
      op(`DABC_OP_CMP_REG, k[1:0], 6'h0, 32'h0180ff10, 32'h02800120, 1'b0, 1'b0);
      chk("both flags", {28'h0, o_cc_flags}, {28'h0, bx[k]});
      chk("both result", o_result, {28'h0, bx[k]});
      idle;
      chk("reg result", o_result, {28'h0, bx[k]});
    end
    axr(`DABC_ADDR_FLAGS);
    chk("flag reg", rd & 32'h0f000000, 32'h0d000000);
    chk("write back", wb, 32'hd);
    axr(`DABC_ADDR_STATUS);
    chk("status set", rd, 32'hf);
    axw(`DABC_ADDR_MASK, 32'h9);
    idle;
    chk("irq on", o_irq, 32'h1);
    axw(`DABC_ADDR_STATUS, 32'hf);
    idle;
    chk("irq off", o_irq, 32'h0);
    axr(`DABC_ADDR_STATUS);
    chk("status", rd, 32'h0);
    close_out;
  end
endmodule
bind dabc_datapath dabc_dp_monitor u_mon (.*);
`default_nettype wire
